// ---- logic/hostdma_pkg.sv ----
// Constants, field layouts and carrier types for the host port DMA block.
// Assumes a 32-bit AXI4-Lite register bus and an 8-bit host byte bus.
package hostdma_pkg;

  // ---------------------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------------------
  localparam int         AXI_AW        = 4;
  localparam int         AXI_DW        = 32;
  localparam logic [3:0] DSP_CTRL_OFS  = 4'h0;
  localparam logic [3:0] DSP_STAT_OFS  = 4'h4;
  localparam logic [3:0] DSP_TXW_OFS   = 4'h8;
  localparam logic [3:0] DSP_RXW_OFS   = 4'hC;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;
  localparam int         CTRL_RXIE_BIT = 0;
  localparam int         CTRL_TXIE_BIT = 1;

  // ---------------------------------------------------------------------------
  // Host byte register selects
  // ---------------------------------------------------------------------------
  localparam logic [2:0] SEL_ICR  = 3'h0;
  localparam logic [2:0] SEL_ISR  = 3'h2;
  localparam logic [2:0] SEL_HIGH = 3'h5;
  localparam logic [2:0] SEL_MID  = 3'h6;
  localparam logic [2:0] SEL_LOW  = 3'h7;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  ICR_RST  = 8'h00;
  localparam logic [7:0]  BYTE_RST = 8'h00;
  localparam logic [23:0] WORD_RST = 24'h000000;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    WS_OFF = 2'b00,
    WS_24  = 2'b01,
    WS_16  = 2'b10,
    WS_8   = 2'b11
  } word_size_t;

  typedef struct packed {
    logic       init;
    word_size_t word_size;
    logic [2:0] spare;
    logic       tx_request_en;
    logic       rx_request_en;
  } host_int_control_t;

  typedef struct packed {
    logic [7:0] data;
    logic [2:0] sel;
    logic       rd;
  } host_sample_t;

endpackage : hostdma_pkg

// ---- logic/sync2.sv ----
// Two-flop level synchroniser, one per bit.
// Assumes the inputs may change at any time relative to the clock.
module sync2 #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= RST_VAL;
      dout   <= RST_VAL;
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end

endmodule : sync2

// ---- logic/host_port_dma_transfer.sv ----
// DMA transfer logic of a DSP host port: host byte bus on one side,
// DSP word registers over AXI4-Lite on the other.
// Assumes an external DMA controller drives the acknowledge and the host drives the strobe for register access.
//
// Our own choices: the address map and register access over AXI4-Lite.
module host_port_dma_transfer (
  input  wire logic        CLK_SYS,
  input  wire logic        ARST_N,
  input  wire logic [3:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [3:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output logic             HOST_REQUEST_N,
  input  wire logic        HOST_DMA_ACK_N,
  input  wire logic        HOST_STROBE_N,
  input  wire logic        HOST_READ,
  input  wire logic [2:0]  HOST_REG_SELECT,
  input  wire logic [7:0]  HOST_BYTE_LINES_I,
  output logic      [7:0]  HOST_BYTE_LINES_O,
  output logic             HOST_BYTE_LINES_OE_N,
  output logic             DSP_RX_IRQ,
  output logic             DSP_TX_IRQ
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  hostdma_pkg::host_int_control_t icr_r;
  hostdma_pkg::host_sample_t      smp1_r, smp2_r;
  logic [7:0]  tx_byte_r [hostdma_pkg::SEL_HIGH:hostdma_pkg::SEL_LOW];
  logic [7:0]  rx_byte_r [hostdma_pkg::SEL_HIGH:hostdma_pkg::SEL_LOW];
  logic [23:0] dsp_rx_word_r, dsp_tx_word_r;
  logic [2:0]  cnt_r;
  logic        tx_bytes_empty_r, rx_bytes_full_r, dsp_rx_full_r, dsp_tx_empty_r;
  logic        word_pending_r, req_r, ack_d_r, stb_d_r;
  logic        dsp_rx_irq_en_r, dsp_tx_irq_en_r;
  logic [7:0]  byte_out_r;
  logic        ack_s, stb_s;

  // Strobes crossed in before any flag or counter acts on them
  sync2 #(.W(2), .RST_VAL(2'b11)) u_sync (
    .clk    (CLK_SYS),
    .arst_n (ARST_N),
    .din    ({HOST_DMA_ACK_N, HOST_STROBE_N}),
    .dout   ({ack_s, stb_s})
  );

  // ---------------------------------------------------------------------------
  // Host side decode
  // ---------------------------------------------------------------------------
  wire dma_on   = icr_r.word_size != hostdma_pkg::WS_OFF;
  wire h2d      = dma_on & icr_r.tx_request_en;
  wire d2h      = dma_on & icr_r.rx_request_en;
  wire ack_rise = ack_s & ~ack_d_r;
  wire ack_low  = ~ack_s;
  wire stb_rise = stb_s & ~stb_d_r & ack_s;
  wire at_low   = cnt_r == hostdma_pkg::SEL_LOW;
  wire dma_wr   = ack_rise & h2d;
  wire dma_rd   = ack_rise & d2h;
  wire host_wr  = stb_rise & ~smp2_r.rd;
  wire host_rd  = stb_rise & smp2_r.rd;
  wire sel_byte = smp2_r.sel >= hostdma_pkg::SEL_HIGH;
  wire init_go  = icr_r.init;
  wire icr_wr   = host_wr & (smp2_r.sel == hostdma_pkg::SEL_ICR);

  // First byte address per size, low byte always last
  wire [2:0] first_cnt = (icr_r.word_size == hostdma_pkg::WS_8)  ? hostdma_pkg::SEL_LOW :
                         (icr_r.word_size == hostdma_pkg::WS_16) ? hostdma_pkg::SEL_MID :
                                                                   hostdma_pkg::SEL_HIGH;

  wire       tx_wr_en    = dma_wr | (host_wr & sel_byte);
  wire [2:0] tx_wr_idx   = dma_wr ? cnt_r : smp2_r.sel;
  wire       low_written = tx_wr_en & (tx_wr_idx == hostdma_pkg::SEL_LOW);
  wire       h2d_move    = word_pending_r & ~dsp_rx_full_r;
  wire       d2h_copy    = ~rx_bytes_full_r & ~dsp_tx_empty_r;
  wire       rx_low_read = (dma_rd & at_low) |
                           (host_rd & (smp2_r.sel == hostdma_pkg::SEL_LOW));
  wire       tx_path_ready = tx_bytes_empty_r & ~dsp_rx_full_r;
  wire       dma_drive     = d2h & ~HOST_DMA_ACK_N;
  wire [2:0] out_idx       = dma_drive ? cnt_r : HOST_REG_SELECT;
  wire [7:0] isr_byte      = {~HOST_REQUEST_N, dma_on, 3'h0, tx_path_ready,
                              tx_bytes_empty_r, rx_bytes_full_r};
  wire [7:0] out_byte      = (out_idx >= hostdma_pkg::SEL_HIGH) ? rx_byte_r[out_idx] :
                             (out_idx == hostdma_pkg::SEL_ISR)  ? isr_byte :
                             (out_idx == hostdma_pkg::SEL_ICR)  ? icr_r : 8'h00;

  // ---------------------------------------------------------------------------
  // Host pins
  // ---------------------------------------------------------------------------
  assign HOST_REQUEST_N       = ~(req_r & HOST_DMA_ACK_N);
  assign HOST_BYTE_LINES_O    = byte_out_r;
  assign HOST_BYTE_LINES_OE_N = ~(dma_drive | (~HOST_STROBE_N & HOST_READ & HOST_DMA_ACK_N));

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      smp1_r     <= '0;
      smp2_r     <= '0;
      ack_d_r    <= 1'b1;
      stb_d_r    <= 1'b1;
      byte_out_r <= hostdma_pkg::BYTE_RST;
    end else begin
      // Pins delayed to line up with the synchronised strobes
      smp1_r     <= '{data: HOST_BYTE_LINES_I, sel: HOST_REG_SELECT, rd: HOST_READ};
      smp2_r     <= smp1_r;
      ack_d_r    <= ack_s;
      stb_d_r    <= stb_s;
      byte_out_r <= out_byte;
    end
  end

  // ---------------------------------------------------------------------------
  // Control register and byte registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      icr_r <= hostdma_pkg::ICR_RST;
    end else if (icr_wr) begin
      icr_r <= smp2_r.data;
    end else begin
      icr_r.init <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      tx_byte_r <= '{default: hostdma_pkg::BYTE_RST};
      rx_byte_r <= '{default: hostdma_pkg::BYTE_RST};
    end else begin
      if (tx_wr_en) begin
        tx_byte_r[tx_wr_idx] <= smp2_r.data;
      end
      if (d2h_copy) begin
        {rx_byte_r[hostdma_pkg::SEL_HIGH], rx_byte_r[hostdma_pkg::SEL_MID],
         rx_byte_r[hostdma_pkg::SEL_LOW]} <= dsp_tx_word_r;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Flags, counter and request
  // ---------------------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      tx_bytes_empty_r <= 1'b1;
      word_pending_r   <= 1'b0;
      rx_bytes_full_r  <= 1'b0;
    end else begin
      tx_bytes_empty_r <= h2d_move | init_go | (tx_bytes_empty_r & ~low_written);
      word_pending_r   <= low_written | (word_pending_r & ~h2d_move);
      rx_bytes_full_r  <= d2h_copy | (rx_bytes_full_r & ~rx_low_read);
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      cnt_r <= hostdma_pkg::SEL_HIGH;
    end else if (init_go | (d2h_copy & d2h) | (low_written & dma_wr)) begin
      cnt_r <= first_cnt;
    end else if (ack_rise & dma_on & ~at_low) begin
      cnt_r <= 3'(cnt_r + 3'h1);
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      req_r <= 1'b0;
    end else if (!dma_on) begin
      req_r <= 1'b0;
    end else if ((init_go & h2d) | (h2d_move & h2d) | (d2h_copy & d2h)) begin
      req_r <= 1'b1;
    end else if (ack_rise & ~at_low) begin
      req_r <= 1'b1;
    end else if (ack_low) begin
      req_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------------------
  logic        aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
  logic [3:0]  aw_addr_r, w_strb_r;
  logic [31:0] w_data_r, rdata_r;
  logic [1:0]  bresp_r, rresp_r;

  wire aw_fire = S_AXI_AWVALID & S_AXI_AWREADY;
  wire w_fire  = S_AXI_WVALID & S_AXI_WREADY;
  wire ar_fire = S_AXI_ARVALID & S_AXI_ARREADY;
  wire wr_do   = aw_hold_r & w_hold_r & ~bvalid_r;
  wire wr_ctrl = wr_do & (aw_addr_r == hostdma_pkg::DSP_CTRL_OFS);
  wire wr_txw  = wr_do & (aw_addr_r == hostdma_pkg::DSP_TXW_OFS);
  wire wr_ok   = wr_ctrl | wr_txw;
  wire rd_rxw  = ar_fire & (S_AXI_ARADDR == hostdma_pkg::DSP_RXW_OFS);
  wire rd_ok   = (S_AXI_ARADDR == hostdma_pkg::DSP_CTRL_OFS) |
                 (S_AXI_ARADDR == hostdma_pkg::DSP_STAT_OFS) |
                 (S_AXI_ARADDR == hostdma_pkg::DSP_TXW_OFS) |
                 (S_AXI_ARADDR == hostdma_pkg::DSP_RXW_OFS);
  wire [31:0] rd_mux =
    (S_AXI_ARADDR == hostdma_pkg::DSP_CTRL_OFS) ? {30'h0, dsp_tx_irq_en_r, dsp_rx_irq_en_r} :
    (S_AXI_ARADDR == hostdma_pkg::DSP_STAT_OFS) ? {29'h0, dma_on, dsp_tx_empty_r, dsp_rx_full_r} :
    (S_AXI_ARADDR == hostdma_pkg::DSP_RXW_OFS)  ? {8'h0, dsp_rx_word_r} : 32'h0;
  wire [23:0] txw_merge = {w_strb_r[2] ? w_data_r[23:16] : dsp_tx_word_r[23:16],
                           w_strb_r[1] ? w_data_r[15:8] : dsp_tx_word_r[15:8],
                           w_strb_r[0] ? w_data_r[7:0] : dsp_tx_word_r[7:0]};

  assign S_AXI_AWREADY = ~aw_hold_r & ~bvalid_r;
  assign S_AXI_WREADY  = ~w_hold_r & ~bvalid_r;
  assign S_AXI_ARREADY = ~rvalid_r;
  assign S_AXI_BVALID  = bvalid_r;
  assign S_AXI_BRESP   = bresp_r;
  assign S_AXI_RVALID  = rvalid_r;
  assign S_AXI_RDATA   = rdata_r;
  assign S_AXI_RRESP   = rresp_r;

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      aw_addr_r <= hostdma_pkg::DSP_CTRL_OFS;
      w_data_r  <= 32'h0;
      w_strb_r  <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= hostdma_pkg::RESP_OKAY;
    end else begin
      if (aw_fire) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= S_AXI_AWADDR;
      end
      if (w_fire) begin
        w_hold_r <= 1'b1;
        w_data_r <= S_AXI_WDATA;
        w_strb_r <= S_AXI_WSTRB;
      end
      if (wr_do) begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_ok ? hostdma_pkg::RESP_OKAY : hostdma_pkg::RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0;
      rresp_r  <= hostdma_pkg::RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_mux;
      rresp_r  <= rd_ok ? hostdma_pkg::RESP_OKAY : hostdma_pkg::RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      rvalid_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // DSP word registers and exceptions
  // ---------------------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      dsp_rx_irq_en_r <= 1'b0;
      dsp_tx_irq_en_r <= 1'b0;
      dsp_tx_word_r   <= hostdma_pkg::WORD_RST;
      dsp_rx_word_r   <= hostdma_pkg::WORD_RST;
      dsp_tx_empty_r  <= 1'b1;
      dsp_rx_full_r   <= 1'b0;
    end else begin
      if (wr_ctrl & w_strb_r[0]) begin
        dsp_rx_irq_en_r <= w_data_r[hostdma_pkg::CTRL_RXIE_BIT];
        dsp_tx_irq_en_r <= w_data_r[hostdma_pkg::CTRL_TXIE_BIT];
      end
      if (wr_txw) begin
        dsp_tx_word_r <= txw_merge;
      end
      if (h2d_move) begin
        dsp_rx_word_r <= {tx_byte_r[hostdma_pkg::SEL_HIGH], tx_byte_r[hostdma_pkg::SEL_MID],
                          tx_byte_r[hostdma_pkg::SEL_LOW]};
      end
      dsp_tx_empty_r <= d2h_copy | (dsp_tx_empty_r & ~wr_txw);
      dsp_rx_full_r  <= h2d_move | (dsp_rx_full_r & ~rd_rxw);
    end
  end

  assign DSP_RX_IRQ = dsp_rx_full_r & dsp_rx_irq_en_r;
  assign DSP_TX_IRQ = dsp_tx_empty_r & dsp_tx_irq_en_r;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  sequence s_low_byte_in;
    dma_wr && at_low;
  endsequence
  sequence s_word_moved;
    ##1 !dsp_rx_full_r ##1 (dsp_rx_full_r && tx_bytes_empty_r);
  endsequence

  property p_req_off_ack;
    @(posedge CLK_SYS) disable iff (!ARST_N) !HOST_DMA_ACK_N |-> HOST_REQUEST_N;
  endproperty
  a_req_off_ack: assert property (p_req_off_ack) else $error("Request during ack");

  property p_sync_lag;
    @(posedge CLK_SYS) disable iff (!ARST_N) ##2 (ack_s == $past(HOST_DMA_ACK_N, 2));
  endproperty
  a_sync_lag: assert property (p_sync_lag) else $error("Ack sync lag wrong");

  property p_init_req;
    @(posedge CLK_SYS) disable iff (!ARST_N) init_go && h2d |=> req_r && tx_bytes_empty_r;
  endproperty
  a_init_req: assert property (p_init_req) else $error("No request after init");

  property p_mid_byte;
    @(posedge CLK_SYS) disable iff (!ARST_N)
      ack_rise && dma_on && !at_low && !init_go |=> cnt_r == $past(cnt_r) + 3'h1 && req_r;
  endproperty
  a_mid_byte: assert property (p_mid_byte) else $error("Counter did not step");

  property p_word_move;
    @(posedge CLK_SYS) disable iff (!ARST_N) s_low_byte_in ##0 !dsp_rx_full_r |-> s_word_moved;
  endproperty
  a_word_move: assert property (p_word_move) else $error("Word not moved");

  property p_rx_irq;
    @(posedge CLK_SYS) disable iff (!ARST_N) $rose(dsp_rx_full_r) && dsp_rx_irq_en_r |-> DSP_RX_IRQ;
  endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("Receive interrupt missing");

  property p_tx_irq;
    @(posedge CLK_SYS) disable iff (!ARST_N) $rose(dsp_tx_irq_en_r) && dsp_tx_empty_r |-> DSP_TX_IRQ;
  endproperty
  a_tx_irq: assert property (p_tx_irq) else $error("Transmit exception missing");

  property p_copy;
    @(posedge CLK_SYS) disable iff (!ARST_N)
      !rx_bytes_full_r && !dsp_tx_empty_r |=> rx_bytes_full_r && dsp_tx_empty_r;
  endproperty
  a_copy: assert property (p_copy) else $error("Copy to receive bytes missing");

  property p_copy_load;
    @(posedge CLK_SYS) disable iff (!ARST_N) d2h && $rose(rx_bytes_full_r) |-> cnt_r == $past(first_cnt) ##0 req_r;
  endproperty
  a_copy_load: assert property (p_copy_load) else $error("Counter not loaded");

  property p_low_read;
    @(posedge CLK_SYS) disable iff (!ARST_N) dma_rd && at_low |=> !rx_bytes_full_r;
  endproperty
  a_low_read: assert property (p_low_read) else $error("Full flag not cleared");

endmodule : host_port_dma_transfer

// ---- tb/dma_ctrl_model.sv ----
// Behavioural DMA controller on the host byte bus.
// Assumes a 50 MHz clock; serves one byte for every request it sees.
module dma_ctrl_model (
  input  wire logic       clk,
  input  wire logic       req_n,
  input  wire logic       oe_n,
  input  wire logic [7:0] din,
  input  wire logic       h2d,
  output logic            ack_n   = 1'b1,
  output logic            drive   = 1'b0,
  output logic [7:0]      dout    = 8'h00,
  output logic            req_err = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] wq [$];
  logic [7:0] rq [$];
  // Request must be gone while acknowledge is low
  always @(posedge clk) begin
    if (ack_n === 1'b0 && req_n !== 1'b1) req_err <= 1'b1;
  end
  // -----------------------------
  // Handshake, ack low 4 and high at least 8 cycles
  // -----------------------------
  initial begin
    forever begin
      @(posedge clk);
      if (req_n === 1'b0 && (!h2d || wq.size() > 0)) begin
        ack_n <= 1'b0;
        drive <= h2d;
        if (h2d) dout <= wq.pop_front();
        repeat (4) @(posedge clk);
        if (!h2d && oe_n !== 1'b0) req_err <= 1'b1;
        if (!h2d) rq.push_back(din);
        ack_n <= 1'b1;
        repeat (4) @(posedge clk);
        dout  <= ~dout;
        drive <= 1'b0;
        repeat (3) @(posedge clk);
      end
    end
  end
endmodule : dma_ctrl_model

// ---- tb/tb_host_port_dma_transfer.sv ----
// Self-checking bench: AXI4-Lite master, host strobe access, DMA partner.
// Assumes the design answers within 50 bus cycles.
module tb_host_port_dma_transfer;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
    $display("wrong value at %0t: %h vs %h", $time, (g), (e)); end end
  logic        clk;
  logic        rst_n = 1'b0;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, rd, w1, w2, msk;
  logic [1:0]  bresp, rresp, resp;
  logic        strb_n = 1'b1, hread = 1'b1, h2d = 1'b1;
  logic [2:0]  sel = 3'h0;
  logic [7:0]  hdat = 8'h00, hout, dmad, hb;
  logic        awrdy, wrdy, bvalid, arrdy, rvalid, req_n, oe_n, rxirq, txirq, ack_n, drv, rerr;
  logic [31:0] seed = 32'h0000_2093;
  int          check_count = 0, n_fail = 0, need, n, k, si;
  hostdma_pkg::word_size_t wl [3] = '{hostdma_pkg::WS_24, hostdma_pkg::WS_16, hostdma_pkg::WS_8};

  host_port_dma_transfer i_dut (.CLK_SYS(clk), .ARST_N(rst_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awrdy),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wrdy),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arrdy),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .HOST_REQUEST_N(req_n), .HOST_DMA_ACK_N(ack_n), .HOST_STROBE_N(strb_n),
    .HOST_READ(hread), .HOST_REG_SELECT(sel), .HOST_BYTE_LINES_I(drv ? dmad : hdat),
    .HOST_BYTE_LINES_O(hout), .HOST_BYTE_LINES_OE_N(oe_n),
    .DSP_RX_IRQ(rxirq), .DSP_TX_IRQ(txirq));

  dma_ctrl_model i_dma (.clk(clk), .req_n(req_n), .oe_n(oe_n), .din(hout), .h2d(h2d),
    .ack_n(ack_n), .drive(drv), .dout(dmad), .req_err(rerr));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop

  // -----------------------------
  // Bus and wait helpers
  // -----------------------------
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    int t;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (t = 0; t < 50; t++) begin
      @(posedge clk);
      if (awvalid && awrdy) awvalid <= 1'b0;
      if (wvalid && wrdy) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    resp = bresp;
    bready <= 1'b0;
    if (t == 50) begin n_fail++; report_and_stop(); end
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a);
    int t;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (t = 0; t < 50; t++) begin
      @(posedge clk);
      if (arvalid && arrdy) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
    if (t == 50) begin n_fail++; report_and_stop(); end
  endtask : axi_rd

  task automatic host_wr(input logic [2:0] s, input logic [7:0] d);
    @(posedge clk);
    sel    <= s;
    hdat   <= d;
    hread  <= 1'b0;
    strb_n <= 1'b0;
    repeat (4) @(posedge clk);
    strb_n <= 1'b1;
    repeat (4) @(posedge clk);
    hread  <= 1'b1;
  endtask : host_wr

  task automatic host_rd(input logic [2:0] s);
    @(posedge clk);
    sel    <= s;
    strb_n <= 1'b0;
    repeat (4) @(posedge clk);
    hb     = hout;
    strb_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : host_rd

  task automatic wt(input int s);
    int t;
    for (t = 0; t < 3000; t++) begin
      @(posedge clk);
      if (s == 0 && rxirq === 1'b1) break;
      if (s == 1 && req_n === 1'b0) break;
      if (s == 2 && i_dma.rq.size() >= need) break;
    end
    if (t == 3000) begin n_fail++; report_and_stop(); end
  endtask : wt

  // -----------------------------
  // Main sequence
  // -----------------------------
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    axi_rd(hostdma_pkg::DSP_STAT_OFS);
    `CHK(rd, 32'h0000_0002)
    `CHK(resp, hostdma_pkg::RESP_OKAY)
    `CHK(req_n, 1'b1)
    host_rd(hostdma_pkg::SEL_ISR);
    w1[7:0] = hb;
    host_rd(hostdma_pkg::SEL_ISR);
    `CHK(hb, w1[7:0])
    `CHK(hb, 8'h06)
    axi_wr(hostdma_pkg::DSP_RXW_OFS, xs());
    `CHK(resp, hostdma_pkg::RESP_SLVERR)
    $display("test reset done");
    for (si = 0; si < 3; si++) begin
      n   = (wl[si] == hostdma_pkg::WS_24) ? 3 : (wl[si] == hostdma_pkg::WS_16) ? 2 : 1;
      msk = (32'h0000_0001 << (8 * n)) - 32'h0000_0001;
      w1  = xs();
      w2  = xs();
      h2d <= 1'b1;
      host_wr(hostdma_pkg::SEL_ICR, {1'b1, wl[si], 5'h02});
      axi_wr(hostdma_pkg::DSP_CTRL_OFS, 32'h0000_0001);
      wt(1);
      for (k = n - 1; k >= 0; k--) i_dma.wq.push_back(w1[8*k+:8]);
      for (k = n - 1; k >= 0; k--) i_dma.wq.push_back(w2[8*k+:8]);
      wt(0);
      axi_rd(hostdma_pkg::DSP_RXW_OFS);
      `CHK(rd & msk, w1 & msk)
      wt(0);
      axi_rd(hostdma_pkg::DSP_RXW_OFS);
      `CHK(rd & msk, w2 & msk)
      @(posedge clk);
      `CHK(rxirq, 1'b0)
      host_wr(hostdma_pkg::SEL_ICR, 8'h00);
      @(posedge clk);
      `CHK(req_n, 1'b1)
      $display("test host to dsp done");
      h2d <= 1'b0;
      host_wr(hostdma_pkg::SEL_ICR, {1'b1, wl[si], 5'h01});
      axi_wr(hostdma_pkg::DSP_CTRL_OFS, 32'h0000_0002);
      `CHK(txirq, 1'b1)
      axi_wr(hostdma_pkg::DSP_TXW_OFS, w1);
      axi_wr(hostdma_pkg::DSP_TXW_OFS, w2);
      `CHK(txirq, 1'b0)
      need = 2 * n;
      wt(2);
      repeat (4) @(posedge clk);
      `CHK(txirq, 1'b1)
      for (k = n - 1; k >= 0; k--) begin
        hb = i_dma.rq.pop_front();
        `CHK(hb, w1[8*k+:8])
      end
      for (k = n - 1; k >= 0; k--) begin
        hb = i_dma.rq.pop_front();
        `CHK(hb, w2[8*k+:8])
      end
      axi_wr(hostdma_pkg::DSP_CTRL_OFS, 32'h0000_0000);
      host_wr(hostdma_pkg::SEL_ICR, 8'h00);
      $display("test dsp to host done");
    end
    `CHK(rerr, 1'b0)
    report_and_stop();
  end
endmodule : tb_host_port_dma_transfer
